// ==== hdl/scdp_clock_divider.sv ====
/*
  scdp_clock_divider: clock pulse generator core. clk is twice the
  oscillator rate; a toggle stage forms the duty-adjusted oscillator
  clock, a counter divides it by the selected ratio into the system
  clock, and a prescaler makes the submultiples as tick pulses.
  assumes mode and standby pins are asynchronous and the stop bit and
  divide writes come from logic on clk.
*/
// Function
// - divide oscillator clock by software ratio
// - prescaler ticks system clock /2 to /4096
// - ratio changes while running, pin follows
// - pin drive depends on mode, stop bit
// - select 00,01,10,11 gives 1,2,4,8
// - reset/hw standby reinit, upper bits one
// - duty correction at 5 MHz and above
`timescale 1ns/1ps
module scdp_clock_divider
  import scdp_pkg::*;
#(
  parameter int SETTLE_CYCLES = SCDP_SETTLE_CYCLES,
  parameter int PRESC_STAGES = SCDP_PRESC_STAGES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby_pin,
  input wire logic single_chip_mode_pin,
  input wire logic osc_freq_high_pin,
  input wire logic sw_standby,
  input wire logic clock_pin_output_stop,
  input wire logic divide_select_wr,
  input wire logic [SCDP_SEL_W-1:0] divide_select_wdata,
  output logic [SCDP_REG_W-1:0] clock_divide_select_register,
  output logic [SCDP_SEL_W-1:0] active_divide_select,
  output logic sys_clk,
  output logic sys_tick,
  output logic [PRESC_STAGES-1:0] presc_tick,
  output logic duty_adjust_active,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  output logic clock_settled
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic hw_standby;
  logic single_chip_mode;
  logic osc_freq_high;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {osc_freq_high_pin, single_chip_mode_pin, hw_standby_pin};
      sync_b <= sync_a;
    end
  end

  assign hw_standby = sync_b[0];
  assign single_chip_mode = sync_b[1];
  assign osc_freq_high = sync_b[2];

  // ************************************************************
  // divide select register and divider
  // ************************************************************
  logic [SCDP_SEL_W-1:0] divide_select;
  logic [SCDP_SEL_W-1:0] next_divide_select;
  logic [SCDP_SEL_W-1:0] next_active;
  logic [SCDP_DIV_CNT_W-1:0] div_cnt;
  logic [SCDP_DIV_CNT_W-1:0] next_div_cnt;
  logic next_sys_clk;
  logic next_sys_tick;
  logic next_duty;
  logic boundary;
  logic [SCDP_DIV_CNT_W-1:0] period_mask;

  always_comb
  begin
    next_divide_select = divide_select;
    if (hw_standby)
    begin
      next_divide_select = SCDP_SEL_RESET;
    end
    else if (divide_select_wr)
    begin
      // software standby leaves the field untouched
      next_divide_select = divide_select_wdata;
    end
  end

  // the low bit of div_cnt is the duty-adjusted oscillator clock;
  // bit n, for n up to the active select, is that clock divided by 2**n
  always_comb
  begin
    period_mask = SCDP_DIV_CNT_W'((2 << active_divide_select) - 1);
    boundary = (div_cnt & period_mask) == period_mask;
    next_active = active_divide_select;
    next_div_cnt = div_cnt + 1'b1;
    next_sys_tick = 1'b0;
    if (hw_standby || sw_standby)
    begin
      next_div_cnt = '0;
      if (hw_standby)
      begin
        next_active = SCDP_SEL_RESET;
      end
    end
    else if (boundary)
    begin
      // restart the count so the new ratio begins with a full low phase
      next_active = divide_select;
      next_div_cnt = '0;
      next_sys_tick = 1'b1;
    end
    next_sys_clk = next_div_cnt[next_active];
    // a toggle stage always yields 50 percent duty
    next_duty = osc_freq_high;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      divide_select <= SCDP_SEL_RESET;
      active_divide_select <= SCDP_SEL_RESET;
      div_cnt <= '0;
      sys_clk <= 1'b0;
      sys_tick <= 1'b0;
      duty_adjust_active <= 1'b0;
    end
    else
    begin
      divide_select <= next_divide_select;
      active_divide_select <= next_active;
      div_cnt <= next_div_cnt;
      sys_clk <= next_sys_clk;
      sys_tick <= next_sys_tick;
      duty_adjust_active <= next_duty;
    end
  end

  assign clock_divide_select_register = {SCDP_REG_RESERVED, divide_select};

  // ************************************************************
  // prescaler
  // ************************************************************
  scdp_prescaler #(
    .STAGES(PRESC_STAGES)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .hold(hw_standby),
    .sys_tick(sys_tick),
    .presc_tick(presc_tick)
  );

  // ************************************************************
  // clock output pin
  // ************************************************************
  logic next_pin_out;
  logic next_pin_oe;

  always_comb
  begin
    next_pin_out = next_sys_clk;
    next_pin_oe = 1'b1;
    if (hw_standby)
    begin
      next_pin_oe = 1'b0;
    end
    else if (clock_pin_output_stop)
    begin
      // single-chip mode frees the pin; expanded modes park it high
      next_pin_out = 1'b1;
      next_pin_oe = !single_chip_mode;
    end
    else if (sw_standby)
    begin
      next_pin_out = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clock_pin_out <= 1'b0;
      clock_pin_oe <= 1'b0;
    end
    else
    begin
      clock_pin_out <= next_pin_out;
      clock_pin_oe <= next_pin_oe;
    end
  end

  // ************************************************************
  // settling indicator
  // ************************************************************
  // informs only; holding reset through settling is the board's job
  logic [SCDP_SETTLE_CNT_W-1:0] settle_cnt;
  logic [SCDP_SETTLE_CNT_W-1:0] next_settle_cnt;
  logic next_settled;

  always_comb
  begin
    next_settle_cnt = settle_cnt;
    next_settled = clock_settled;
    if (settle_cnt >= SCDP_SETTLE_CNT_W'(SETTLE_CYCLES - 1))
    begin
      next_settled = 1'b1;
    end
    else
    begin
      next_settle_cnt = settle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      settle_cnt <= '0;
      clock_settled <= 1'b0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      clock_settled <= next_settled;
    end
  end
endmodule // scdp_clock_divider

// ==== hdl/scdp_prescaler.sv ====
/*
  scdp_prescaler: binary prescaler fed by system clock ticks.
  assumes sys_tick is a one-cycle pulse on the same clock, once per
  system clock period.
*/
`timescale 1ns/1ps
module scdp_prescaler
  import scdp_pkg::*;
#(
  parameter int STAGES = SCDP_PRESC_STAGES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic sys_tick,
  output logic [STAGES-1:0] presc_tick
);
  logic [STAGES-1:0] cnt;
  logic [STAGES-1:0] next_cnt;
  logic [STAGES-1:0] next_tick;
  logic carry;

  always_comb
  begin
    next_cnt = cnt;
    next_tick = '0;
    carry = 1'b1;
    if (hold)
    begin
      next_cnt = '0;
    end
    else if (sys_tick)
    begin
      next_cnt = cnt + 1'b1;
      for (int i = 0; i < STAGES; i++)
      begin
        // stage i fires every 2**(i+1) system periods
        carry = carry & cnt[i];
        next_tick[i] = carry;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      presc_tick <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      presc_tick <= next_tick;
    end
  end
endmodule // scdp_prescaler

// ==== pkg/scdp_pkg.sv ====
/*
  scdp_pkg: constants shared by the system clock divider and its prescaler.
  assumes a single 100 MHz clock; no software bus reaches this block.
*/
package scdp_pkg;
  // ************************************************************
  // divide select field
  // ************************************************************
  localparam int SCDP_SEL_W = 2;
  localparam logic [1:0] SCDP_SEL_RESET = 2'h0;
  localparam int SCDP_REG_W = 8;
  localparam logic [5:0] SCDP_REG_RESERVED = 6'h3f;
  localparam int SCDP_SEL_LSB = 0;
  localparam int SCDP_RSV_LSB = 2;
  // ************************************************************
  // divider and prescaler sizes
  // ************************************************************
  localparam int SCDP_DIV_CNT_W = 4;
  localparam int SCDP_PRESC_STAGES = 12;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int SCDP_CLK_MHZ = 100;
  localparam int SCDP_SETTLE_US = 500;
  localparam int SCDP_SETTLE_CYCLES = SCDP_SETTLE_US * SCDP_CLK_MHZ;
  localparam int SCDP_SETTLE_CNT_W = 32;
endpackage

// ==== sim/scdp_osc_model.sv ====
/* scdp_osc_model: the clock source beside the divider.
   assumes the bench clock runs at twice the oscillator rate; reset is owned here. */
`timescale 1ns/1ps
module scdp_osc_model #(
  parameter int HOLD = 4
)
(
  input wire logic clk,
  input wire logic restart,
  input wire logic [7:0] freq_mhz,
  output logic rst,
  output logic osc_freq_high_pin
);
  int cnt = 0;
  // sources under 2 MHz do not exist; slower clocks come from the divider
  assign osc_freq_high_pin = (freq_mhz < 8'h02 ? 8'h02 : freq_mhz) >= 8'h05;
  always @(posedge clk)
    cnt <= restart ? 0 : (cnt < HOLD ? cnt + 1 : cnt);
  assign rst = cnt < HOLD;
endmodule // scdp_osc_model

// ==== sim/scdp_sva.sv ====
/* scdp_sva: port checks for the clock divider.
   assumes one clock and a bind onto scdp_clock_divider. */
`timescale 1ns/1ps
module scdp_sva
  import scdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby_pin,
  input wire logic sw_standby,
  input wire logic clock_pin_output_stop,
  input wire logic divide_select_wr,
  input wire logic [SCDP_SEL_W-1:0] divide_select_wdata,
  input wire logic [SCDP_REG_W-1:0] clock_divide_select_register,
  input wire logic [SCDP_SEL_W-1:0] active_divide_select,
  input wire logic sys_clk,
  input wire logic sys_tick,
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  input wire logic clock_settled
);
  wire logic [7:0] rb = clock_divide_select_register;
  wire logic [1:0] act = active_divide_select;
  wire logic hw = hw_standby_pin;
  wire logic stop = clock_pin_output_stop;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ************************************************************
  // assertions
  // ************************************************************
  AST_RSV: assert property (rb[7:2] == SCDP_REG_RESERVED)
    else $error("reserved bits not one");
  AST_RST: assert property ($fell(rst) |-> rb == 8'hfc && act == 2'h0 && !clock_settled)
    else $error("bad state after reset");
  // standby pin is synchronised, so demand it quiet for the whole lag
  AST_WR: assert property (divide_select_wr && !hw && !$past(hw) && !$past(hw, 2)
    |=> rb[1:0] == $past(divide_select_wdata))
    else $error("write not read back");
  AST_GAP8: assert property (sys_tick && act == 2'h3 |=> !sys_tick [*8])
    else $error("short period at ratio 8");
  AST_SWITCH: assert property ($changed(act) && act != 2'h0 |-> sys_tick)
    else $error("ratio switched mid period");
  AST_TICK: assert property (sys_tick |=> !sys_tick)
    else $error("tick longer than one cycle");
  AST_PIN: assert property (!stop && !$past(stop) && !sw_standby && !$past(sw_standby)
    && clock_pin_oe |-> clock_pin_out == sys_clk)
    else $error("pin not following system clock");
  AST_STOP: assert property (stop && $past(stop) |-> !clock_pin_oe || clock_pin_out)
    else $error("stopped pin toggling");
endmodule // scdp_sva
bind scdp_clock_divider scdp_sva sva (.clk, .rst, .hw_standby_pin, .sw_standby,
  .clock_pin_output_stop, .divide_select_wr, .divide_select_wdata,
  .clock_divide_select_register, .active_divide_select, .sys_clk, .sys_tick,
  .clock_pin_out, .clock_pin_oe, .clock_settled);

// ==== sim/tb_system_clock_divider_prescaler.sv ====
/* tb_system_clock_divider_prescaler: self-checking bench for the divider.
   assumes the source model owns reset; settle count cut to 20 cycles. */
`timescale 1ns/1ps
module tb_system_clock_divider_prescaler;
  import scdp_pkg::*;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic restart = 1'b0, hw = 1'b0, mode = 1'b0, sw = 1'b0, stop = 1'b0, wr = 1'b0;
  logic [1:0] wdata = 2'h0;
  logic [7:0] freq = 8'h0a;
  logic rst, osc_hi, sclk, stick, duty, pout, poe, settled;
  logic [7:0] rb;
  logic [1:0] act;
  logic [11:0] pt;
  wire logic [12:0] pulses = {pt, stick};
  logic [31:0] seed = 32'h00005c86;
  int miscompares = 0, comparisons = 0, n = 0;
  int wr_q[$];
  // ************************************************************
  // clock, source and design
  // ************************************************************
  always #5 clk = ~clk;
  scdp_osc_model #(.HOLD(4)) src (.clk(clk), .restart(restart), .freq_mhz(freq), .rst(rst),
    .osc_freq_high_pin(osc_hi));
  scdp_clock_divider #(.SETTLE_CYCLES(SETTLE)) dut (.clk(clk), .rst(rst), .hw_standby_pin(hw),
    .single_chip_mode_pin(mode), .osc_freq_high_pin(osc_hi), .sw_standby(sw),
    .clock_pin_output_stop(stop), .divide_select_wr(wr), .divide_select_wdata(wdata),
    .clock_divide_select_register(rb), .active_divide_select(act), .sys_clk(sclk),
    .sys_tick(stick), .presc_tick(pt), .duty_adjust_active(duty), .clock_pin_out(pout),
    .clock_pin_oe(poe), .clock_settled(settled));
  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_sel(input logic [1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    // the model drops writes made while standby holds the field
    if (!hw)
    begin
      wr_q.push_back(v);
    end
  endtask
  // cycles up to the next pulse; bounded so a dead divider cannot hang us
  task automatic next(input int j);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (pulses[j] !== 1'b1 && n < 20000);
  endtask
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial
  begin
    tick(6);
    chk("reset readback", rb, 8'hfc);
    chk("reset ratio", act, 2'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr_sel(s[1:0]);
      next(0);
      next(0);
      chk("period", n, 2 << s);
      chk("active", act, s);
      chk("readback", rb, {SCDP_REG_RESERVED, s[1:0]});
      chk("pin", {poe, pout}, {1'b1, sclk});
      chk("low phase", sclk, 1'b0);
      tick(1 << s);
      chk("high phase", sclk, 1'b1);
    end
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr_sel(seed[1:0]);
    end
    next(0);
    next(0);
    chk("last write", n, 2 << wr_q[$]);
    chk("last readback", rb, {SCDP_REG_RESERVED, 2'(wr_q[$])});
    wr_sel(2'h0);
    next(0);
    for (int i = 1; i < 13; i += 11)
    begin
      next(i);
      next(i);
      chk("prescaler", n, 4 << (i - 1));
    end
    wr_sel(2'h2);
    @(posedge clk) stop <= 1'b1;
    tick(4);
    chk("stop expanded", {poe, pout}, 2'h3);
    @(posedge clk) mode <= 1'b1;
    tick(4);
    chk("stop single chip", poe, 1'b0);
    @(posedge clk) {stop, sw} <= 2'h1;
    tick(4);
    chk("sw standby", {rb, poe, pout}, 10'h3fb);
    @(posedge clk) {hw, sw} <= 2'h2;
    tick(4);
    wr_sel(2'h1);
    tick(2);
    chk("hw standby", {rb, poe}, 9'h1f8);
    @(posedge clk) {hw, freq} <= {1'b0, 8'h04};
    tick(6);
    chk("duty low", duty, 1'b0);
    seed = xs(seed);
    @(posedge clk) freq <= seed[7:0] | 8'h05;
    tick(6);
    chk("duty high", duty, 1'b1);
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
    tick(1);
    while (rst === 1'b1)
      tick(1);
    chk("restart", {rb, settled}, 9'h1f8);
    tick(SETTLE - 1);
    chk("settling", settled, 1'b0);
    tick(3);
    chk("settled", settled, 1'b1);
    test_done();
  end
  initial
  begin
    // the sequence needs about 17k cycles; 100k means a hang
    #1000000;
    miscompares++;
    test_done();
  end
endmodule // tb_system_clock_divider_prescaler
